// [core/pmi_pkg.sv]
// Purpose: shared constants and types for the MAC data interface of one port
// Assumes: clk_sys is the internal reference and runs at 10 MHz
// Notes: clock rates below the system rate are made by dividing clk_sys
package pmi_pkg;

  typedef enum logic [1:0] {PMI_MII, PMI_RMII, PMI_SERIAL} pmi_mode_type;

  // rates
  localparam longint CLK_SYS_HZ = 64'd10_000_000;
  localparam longint MII_FAST_HZ = 64'd25_000_000;
  localparam longint MII_SLOW_HZ = 64'd2_500_000;
  localparam longint SERIAL_HZ = 64'd10_000_000;
  localparam int CLK_PERIOD_NS = 100;

  // heartbeat (sqe test) pulse length
  localparam int SQE_NS = 1000;
  localparam int SQE_CYCLES = (SQE_NS / CLK_PERIOD_NS < 1) ? 1 : SQE_NS / CLK_PERIOD_NS;
  localparam int HB_W = 5;

  // clock divider half periods, rounded down, never below one cycle
  localparam int DIV_W = 8;
  localparam int HALF_MII_FAST = (CLK_SYS_HZ / (2 * MII_FAST_HZ) < 1) ? 1
                                 : int'(CLK_SYS_HZ / (2 * MII_FAST_HZ));
  localparam int HALF_MII_SLOW = (CLK_SYS_HZ / (2 * MII_SLOW_HZ) < 1) ? 1
                                 : int'(CLK_SYS_HZ / (2 * MII_SLOW_HZ));
  localparam int HALF_SERIAL = (CLK_SYS_HZ / (2 * SERIAL_HZ) < 1) ? 1
                               : int'(CLK_SYS_HZ / (2 * SERIAL_HZ));

  // data path
  localparam int NIB_W = 4;
  localparam int RX_WORD_W = 5;
  localparam int RX_ERR_BIT = 4;
  localparam int FIFO_DEPTH = 32;
  localparam int UNIT_W = 3;
  localparam logic [1:0] RMII_ERR_CODE = 2'h1;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic MDIO_IDLE = 1'b1;

  // pin synchroniser vector layout
  localparam int PIN_W = 7;
  localparam int PIN_TXEN = 4;
  localparam int PIN_MDC = 5;
  localparam int PIN_MDIO = 6;

endpackage

// [core/pmi_fifo.sv]
// Purpose: flip-flop fifo with valid/ready on both sides
// Assumes: single clock, synchronous active-low reset, clock enable freezes state
// Notes: in_ready is registered so that it can leave the block as a flop output
`timescale 1ns/1ps
module pmi_fifo
#(
  parameter int W = 5,
  parameter int DEPTH = 32
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  // fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  logic push;
  logic pop;

  assign push = ce && in_valid && in_ready;
  assign pop = ce && out_valid && out_ready;
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_r];

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (push && !pop)
      cnt_nxt = cnt_r + 1'b1;
    else if (pop && !push)
      cnt_nxt = cnt_r - 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem_r[wr_r] <= in_data;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
      in_ready <= 1'b0;
    end
    else if (ce)
    begin
      if (push)
        wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      if (pop)
        rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      cnt_r <= cnt_nxt;
      // full is honest: ready drops the cycle the last slot fills
      in_ready <= (cnt_nxt < (AW + 1)'(DEPTH));
    end
  end

endmodule

// [core/pmi_mac_port.sv]
// Purpose: MAC-facing data interface of one transceiver port (MII, RMII, 10M serial)
// Assumes: clk_sys is the reference; media side logic runs on clk_sys
// Notes: mode, speed, duplex and heartbeat are taken only while the port is idle
`timescale 1ns/1ps
// Functional notes
// - MII transmit clock runs at 25 MHz (100M) or 2.5 MHz (10M) from reference; at 100M this port gives 5 MHz from the 10 MHz clk_sys.
// - RMII leaves both clock outputs unused; all timing from 50 MHz reference; this port times RMII from the 10 MHz clk_sys, one beat per cycle.
// - transmit enable high marks valid data: 4, 2 or 1 bits per mode.
// - transmit data sampled on transmit clock (MII) or reference (RMII, 2 bits).
// - MII receive clock is 25 MHz at 100M and 2.5 MHz at 10M; at 100M this port gives 5 MHz.
// - serial mode receive clock is 10 MHz; this port gives 5 MHz, the divider half period being held at one cycle.
// - receive data valid high while valid nibble or dibit present; unused serially.
// - MII 100M raises receive error on invalid symbol inside a packet.
// - RMII 100M raises receive error on invalid symbol with crs_dv, or false carrier.
// - RMII corrupts receive data whenever receive error occurs; this port does so only while rx_dv is high.
// - MII drives four receive bits on receive clock, valid while data valid high.
// - RMII drives two receive bits on the reference clock.
// - serial drives one receive bit framed by carrier; upper three bits unused.
// - MII and serial hold carrier sense high while medium is non-idle.
// - RMII outputs one combined carrier sense and data valid signal; this port drives crs and rx_dv separately.
// - MII half duplex raises collision on simultaneous transmit and receive.
// - 10M half duplex with heartbeat pulses collision about 1 us after transmit; this port raises it at once when transmit ends and holds it 1 us (10 cycles).
// - full duplex holds collision low and gives no heartbeat.
// - serial mode raises collision on simultaneous transmit and receive.
// - management data line is shared, driven by manager or by this device.
module pmi_mac_port
  import pmi_pkg::*;
#(
  parameter int FIFO_W = RX_WORD_W,
  parameter int FIFO_D = FIFO_DEPTH
)
(
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  // configuration
  input wire pmi_mode_type cfg_mode,
  input wire logic cfg_fast,
  input wire logic cfg_full,
  input wire logic cfg_heartbeat,
  // MAC transmit pins
  output logic tx_clk,
  input wire logic tx_en,
  input wire logic [3:0] txd,
  // MAC receive pins
  output logic rx_clk,
  output logic rx_dv,
  output logic rx_er,
  output logic [3:0] rxd,
  output logic crs,
  output logic col,
  // management pins
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_n,
  // management engine side
  input wire logic mgmt_drive,
  input wire logic mgmt_bit,
  output logic mgmt_mdc,
  output logic mgmt_mdio_in,
  // media transmit side
  output logic med_tx_valid,
  output logic [3:0] med_tx_data,
  // media receive side
  input wire logic med_rx_valid,
  input wire logic [3:0] med_rx_data,
  input wire logic med_rx_sym_err,
  input wire logic med_rx_false_carrier,
  input wire logic med_rx_carrier,
  output logic med_rx_ready
);

  function automatic logic [DIV_W-1:0] half_of(pmi_mode_type m, logic fast);
    logic [DIV_W-1:0] h;
    h = DIV_W'(HALF_SERIAL);
    if (m == PMI_MII)
      h = fast ? DIV_W'(HALF_MII_FAST) : DIV_W'(HALF_MII_SLOW);
    return h;
  endfunction

  function automatic logic [UNIT_W-1:0] units_of(pmi_mode_type m);
    logic [UNIT_W-1:0] u;
    unique case (m)
      PMI_MII: u = UNIT_W'(1);
      PMI_RMII: u = UNIT_W'(2);
      PMI_SERIAL: u = UNIT_W'(4);
    endcase
    return u;
  endfunction

  pmi_mode_type cfg_mode_r;
  logic cfg_fast_r;
  logic cfg_full_r;
  logic cfg_hb_r;
  logic [PIN_W-1:0] sync1_r;
  logic [PIN_W-1:0] sync2_r;
  logic [PIN_W-1:0] sync3_r;
  logic [PIN_W-1:0] pin_f_r;
  logic [DIV_W-1:0] div_cnt_r;
  logic phase_r;
  logic div_wrap;
  logic beat;
  logic tx_act;
  logic [3:0] txd_f;
  logic tx_act_prev_r;
  logic [3:0] tx_sh_r;
  logic [1:0] tx_cnt_r;
  logic [3:0] tx_nib;
  logic tx_done;
  logic [3:0] rx_sh_r;
  logic [UNIT_W-1:0] rx_left_r;
  logic rx_err_r;
  logic rx_busy_r;
  logic [3:0] rx_src;
  logic rx_src_err;
  logic rx_have;
  logic fifo_pop;
  logic fifo_valid;
  logic [FIFO_W-1:0] fifo_data;
  logic [HB_W-1:0] hb_cnt_r;
  logic [HB_W-1:0] hb_cnt_nxt;
  logic hb_start;
  logic idle;

  assign tx_act = pin_f_r[PIN_TXEN];
  assign txd_f = pin_f_r[3:0];

  // pins from the MAC and the station manager: three flops, change taken on agreement
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end
    else if (ce)
    begin
      sync1_r <= {mdio_i, mdc, tx_en, txd};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  for (genvar i = 0; i < PIN_W; i++)
  begin : g_pin_filter
    always_ff @(posedge clk_sys)
    begin
      if (!rstn)
        pin_f_r[i] <= 1'b0;
      else if (ce && (sync2_r[i] == sync3_r[i]))
        pin_f_r[i] <= sync3_r[i];
    end
  end

  // configuration only moves while nothing is in flight
  assign idle = !tx_act && !tx_act_prev_r && !med_rx_carrier && !rx_busy_r
                && !fifo_valid && (hb_cnt_r == '0);

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      cfg_mode_r <= PMI_MII;
      cfg_fast_r <= 1'b1;
      cfg_full_r <= 1'b0;
      cfg_hb_r <= 1'b0;
    end
    else if (ce && idle)
    begin
      cfg_mode_r <= cfg_mode;
      cfg_fast_r <= cfg_fast;
      cfg_full_r <= cfg_full;
      cfg_hb_r <= cfg_heartbeat;
    end
  end

  // clock divider; a beat is the rising edge of the interface clock
  assign div_wrap = (div_cnt_r >= half_of(cfg_mode_r, cfg_fast_r) - 1'b1);
  assign beat = ce && ((cfg_mode_r == PMI_RMII) || (div_wrap && !phase_r));

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      div_cnt_r <= '0;
      phase_r <= 1'b0;
      tx_clk <= 1'b0;
      rx_clk <= 1'b0;
    end
    else if (ce)
    begin
      div_cnt_r <= div_wrap ? '0 : div_cnt_r + 1'b1;
      if (div_wrap)
        phase_r <= !phase_r;
      // RMII keeps both clock pins parked low
      tx_clk <= (cfg_mode_r != PMI_RMII) && (div_wrap ? !phase_r : phase_r);
      rx_clk <= (cfg_mode_r != PMI_RMII) && (div_wrap ? !phase_r : phase_r);
    end
  end

  // transmit: gather 4, 2 or 1 bits per beat into nibbles for the media side
  always_comb
  begin
    tx_nib = txd_f;
    tx_done = 1'b1;
    unique case (cfg_mode_r)
      PMI_MII:
      begin
        tx_nib = txd_f;
        tx_done = 1'b1;
      end
      PMI_RMII:
      begin
        tx_nib = (tx_cnt_r == 2'h0) ? {2'h0, txd_f[1:0]} : {txd_f[1:0], tx_sh_r[1:0]};
        tx_done = (tx_cnt_r == 2'h1);
      end
      PMI_SERIAL:
      begin
        tx_nib = tx_sh_r | (NIB_W'(txd_f[0]) << tx_cnt_r);
        tx_done = (tx_cnt_r == 2'h3);
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      tx_sh_r <= '0;
      tx_cnt_r <= '0;
      med_tx_valid <= 1'b0;
      med_tx_data <= '0;
    end
    else if (ce)
    begin
      med_tx_valid <= 1'b0;
      if (!tx_act)
      begin
        // a partial nibble at the end of a frame is dropped
        tx_sh_r <= '0;
        tx_cnt_r <= '0;
      end
      else if (beat)
      begin
        if (tx_done)
        begin
          med_tx_valid <= 1'b1;
          med_tx_data <= tx_nib;
          tx_sh_r <= '0;
          tx_cnt_r <= '0;
        end
        else
        begin
          tx_sh_r <= tx_nib;
          tx_cnt_r <= tx_cnt_r + 1'b1;
        end
      end
    end
  end

  // receive: the fifo absorbs media bursts while the MAC side drains at beat rate
  pmi_fifo #(.W(FIFO_W), .DEPTH(FIFO_D)) u_rx_fifo
  (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ce(ce),
    .in_valid(med_rx_valid),
    .in_data({med_rx_sym_err, med_rx_data}),
    .in_ready(med_rx_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(fifo_pop)
  );

  assign fifo_pop = beat && (rx_left_r == '0);
  assign rx_have = (rx_left_r != '0) || fifo_valid;
  assign rx_src = (rx_left_r != '0) ? rx_sh_r : fifo_data[3:0];
  assign rx_src_err = (rx_left_r != '0) ? rx_err_r : fifo_data[RX_ERR_BIT];

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      rx_sh_r <= '0;
      rx_left_r <= '0;
      rx_err_r <= 1'b0;
      rx_busy_r <= 1'b0;
    end
    else if (beat)
    begin
      rx_busy_r <= rx_have;
      if (rx_left_r != '0)
        rx_left_r <= rx_left_r - 1'b1;
      else if (fifo_valid)
        rx_left_r <= units_of(cfg_mode_r) - 1'b1;
      rx_err_r <= rx_src_err;
      unique case (cfg_mode_r)
        PMI_MII: rx_sh_r <= NIB_ZERO;
        PMI_RMII: rx_sh_r <= rx_src >> 2;
        PMI_SERIAL: rx_sh_r <= rx_src >> 1;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      rxd <= '0;
      rx_dv <= 1'b0;
      rx_er <= 1'b0;
    end
    else if (beat)
    begin
      unique case (cfg_mode_r)
        PMI_MII:
        begin
          rxd <= rx_have ? rx_src : NIB_ZERO;
          rx_dv <= rx_have;
          rx_er <= rx_have && rx_src_err && cfg_fast_r;
        end
        PMI_RMII:
        begin
          // at 100M any errored unit is replaced so a MAC ignoring rx_er still sees the error
          if (rx_have && cfg_fast_r && (rx_src_err || med_rx_false_carrier))
            rxd <= {2'h0, RMII_ERR_CODE};
          else
            rxd <= rx_have ? {2'h0, rx_src[1:0]} : NIB_ZERO;
          rx_dv <= rx_have;
          rx_er <= cfg_fast_r && ((rx_have && rx_src_err) || med_rx_false_carrier);
        end
        PMI_SERIAL:
        begin
          rxd <= {3'h0, rx_have & rx_src[0]};
          rx_dv <= 1'b0;
          rx_er <= 1'b0;
        end
      endcase
    end
  end

  // carrier is the medium level held on while received data drains, refreshed every enabled cycle
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      crs <= 1'b0;
    else if (ce)
      crs <= med_rx_carrier || rx_busy_r || fifo_valid;
  end

  // collision and heartbeat
  assign hb_start = tx_act_prev_r && !tx_act && cfg_hb_r && !cfg_fast_r && !cfg_full_r
                    && (cfg_mode_r != PMI_RMII);

  always_comb
  begin
    hb_cnt_nxt = hb_cnt_r;
    if (hb_start)
      hb_cnt_nxt = HB_W'(SQE_CYCLES);
    else if (hb_cnt_r != '0)
      hb_cnt_nxt = hb_cnt_r - 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      tx_act_prev_r <= 1'b0;
      hb_cnt_r <= '0;
      col <= 1'b0;
    end
    else if (ce)
    begin
      tx_act_prev_r <= tx_act;
      hb_cnt_r <= hb_cnt_nxt;
      // full duplex and RMII never show collision
      col <= !cfg_full_r && (cfg_mode_r != PMI_RMII)
             && ((tx_act && med_rx_carrier) || (hb_cnt_nxt != '0));
    end
  end

  // management pins: the frame engine lives elsewhere; oe_n low while we drive
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      mdio_o <= MDIO_IDLE;
      mdio_oe_n <= 1'b1;
      mgmt_mdc <= 1'b0;
      mgmt_mdio_in <= MDIO_IDLE;
    end
    else if (ce)
    begin
      mdio_o <= mgmt_bit;
      mdio_oe_n <= !mgmt_drive;
      mgmt_mdc <= pin_f_r[PIN_MDC];
      mgmt_mdio_in <= pin_f_r[PIN_MDIO];
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_full_no_col: assert property (cfg_full_r |-> !col)
    else $error("collision seen in full duplex");
  a_rmii_clk_parked: assert property (
    ($past(cfg_mode_r) == PMI_RMII) && (cfg_mode_r == PMI_RMII) |-> !tx_clk && !rx_clk)
    else $error("clock pin toggles in rmii");
  a_serial_rx_upper: assert property (
    (cfg_mode_r == PMI_SERIAL) && $stable(cfg_mode_r) |=> (rxd[3:1] == 3'h0) && !rx_dv)
    else $error("upper receive bits used in serial mode");
  a_col_overlap: assert property (
    ce && !cfg_full_r && (cfg_mode_r == PMI_MII) && tx_act && med_rx_carrier |=> col)
    else $error("overlap without collision");
  a_sqe_pulse: assert property (
    ce && hb_start |=> col && (hb_cnt_r == HB_W'(SQE_CYCLES)))
    else $error("heartbeat pulse missing");
  a_rmii_err_corrupt: assert property (
    (cfg_mode_r == PMI_RMII) && rx_er && rx_dv |-> (rxd[1:0] == RMII_ERR_CODE))
    else $error("rmii error without corrupted data");
  a_mii_slow_no_er: assert property (
    (cfg_mode_r == PMI_MII) && !cfg_fast_r && $stable(cfg_fast_r) |=> !rx_er)
    else $error("receive error at 10M in mii");
  a_tx_valid_pulse: assert property (med_tx_valid && ce |=> !med_tx_valid)
    else $error("transmit nibble strobe longer than a cycle");
  a_mdio_drive: assert property (ce && mgmt_drive |=> !mdio_oe_n)
    else $error("mdio not driven when asked");

endmodule

// [test/pmi_mac_model.sv]
// Purpose: behavioural MAC and station manager on the far side of one port
// Assumes: the bench holds go until busy rises
// Notes: idle txd keeps changing so stale data never passes for a frame
`timescale 1ns/1ps
module pmi_mac_model
  import pmi_pkg::*;
(
  // clocks and mode
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic tx_clk,
  input wire pmi_mode_type mode,
  // frame request
  input wire logic go,
  input wire logic [5:0] units,
  input wire logic [31:0] bits,
  output logic busy,
  // data pins
  output logic tx_en,
  output logic [3:0] txd,
  input wire logic crs,
  output logic mac_col,
  // management pins
  input wire logic mgr_drive,
  input wire logic mgr_bit,
  input wire logic mdio_o,
  input wire logic mdio_oe_n,
  output logic mdc,
  output logic mdio_i
);
  logic [5:0] left_r;
  logic [31:0] sh_r;
  logic [2:0] div_r;
  logic tq_r;
  wire [2:0] w = (mode == PMI_MII) ? 3'h4 : (mode == PMI_RMII) ? 3'h2 : 3'h1;
  assign busy = (left_r != 6'h0) || tx_en;
  assign mac_col = crs && tx_en;
  // pull-up level unless someone pulls low
  assign mdio_i = (mdio_oe_n || mdio_o) && (!mgr_drive || mgr_bit);
  initial
  begin
    tx_en = 1'b0;
    txd = 4'h0;
    mdc = 1'b0;
  end
  always @(posedge clk_sys)
  begin
    tq_r <= tx_clk;
    if (!rstn)
    begin
      left_r <= 6'h0;
      tx_en <= 1'b0;
      mdc <= 1'b0;
      div_r <= 3'h0;
    end
    else
    begin
      // 1 MHz, well under the management ceiling; still outside frames
      div_r <= (mgr_drive && div_r != 3'h4) ? div_r + 3'h1 : 3'h0;
      mdc <= mgr_drive && (mdc ^ (div_r == 3'h4));
      // launch one cycle after the device clock rises, or every cycle in RMII
      if (mode == PMI_RMII || (tx_clk && !tq_r))
      begin
        if (left_r != 6'h0)
        begin
          tx_en <= 1'b1;
          txd <= sh_r[3:0];
          sh_r <= sh_r >> w;
          left_r <= left_r - 6'h1;
        end
        else
        begin
          tx_en <= 1'b0;
          txd <= ~txd;
          if (go)
          begin
            sh_r <= bits;
            left_r <= units;
          end
        end
      end
    end
  end
endmodule

// [test/test_pmi_mac_port.sv]
// Purpose: self-checking bench for one MAC data port
// Assumes: clocks and beats as the port divides them from clk_sys
// Notes: received units are matched as a run inside the capture
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module test_pmi_mac_port
  import pmi_pkg::*;
;
  logic clk_sys = 1'b0, rstn = 1'b0, ce = 1'b1;
  pmi_mode_type cfg_mode = PMI_MII;
  logic cfg_fast = 1'b1, cfg_full = 1'b0, cfg_heartbeat = 1'b0;
  logic med_rx_valid = 1'b0, med_rx_sym_err = 1'b0, med_rx_false_carrier = 1'b0;
  logic med_rx_carrier = 1'b0, mgmt_drive = 1'b0, mgmt_bit = 1'b0;
  logic [3:0] med_rx_data = 4'h0;
  logic go = 1'b0, mgr_drive = 1'b0, mgr_bit = 1'b0;
  logic [5:0] units = 6'h0;
  logic [31:0] bits = 32'h0;
  wire tx_clk, tx_en, rx_clk, rx_dv, rx_er, crs, col, mdc, mdio_i, mdio_o, mdio_oe_n;
  wire mgmt_mdc, mgmt_mdio_in, med_tx_valid, med_rx_ready, busy, mac_col;
  wire [3:0] txd, rxd, med_tx_data;
  int miscompares = 0, cmp_count = 0, col_cnt = 0, mac_cnt = 0, refused;
  logic rq, a;
  logic [4:0] rxq[$];
  logic [3:0] txq[$];
  wire [3:0] msk = (cfg_mode == PMI_MII) ? 4'hF : (cfg_mode == PMI_RMII) ? 4'h3 : 4'h1;
  pmi_mode_type rm [5] = '{PMI_MII, PMI_MII, PMI_SERIAL, PMI_RMII, PMI_RMII};
  logic rf [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
  logic rc [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  int rp [5] = '{2 * HALF_MII_FAST, 2 * HALF_MII_SLOW, 2 * HALF_SERIAL, 0, 0};
  int tu [5] = '{4, 4, 8, 8, 8};
  int tn [5] = '{4, 4, 2, 4, 4};
  logic [31:0] tw [5] = '{32'h3C96, 32'h3C96, 32'hA5, 32'hAAAA, 32'hAAAA};

  pmi_mac_port u_pmi_mac_port (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .cfg_mode(cfg_mode),
    .cfg_fast(cfg_fast), .cfg_full(cfg_full), .cfg_heartbeat(cfg_heartbeat), .tx_clk(tx_clk),
    .tx_en(tx_en), .txd(txd), .rx_clk(rx_clk), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd),
    .crs(crs), .col(col), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n),
    .mgmt_drive(mgmt_drive), .mgmt_bit(mgmt_bit), .mgmt_mdc(mgmt_mdc),
    .mgmt_mdio_in(mgmt_mdio_in), .med_tx_valid(med_tx_valid), .med_tx_data(med_tx_data),
    .med_rx_valid(med_rx_valid), .med_rx_data(med_rx_data), .med_rx_sym_err(med_rx_sym_err),
    .med_rx_false_carrier(med_rx_false_carrier), .med_rx_carrier(med_rx_carrier),
    .med_rx_ready(med_rx_ready));
  pmi_mac_model u_pmi_mac_model (.clk_sys(clk_sys), .rstn(rstn), .tx_clk(tx_clk),
    .mode(cfg_mode), .go(go), .units(units), .bits(bits), .busy(busy), .tx_en(tx_en),
    .txd(txd), .crs(crs), .mac_col(mac_col), .mgr_drive(mgr_drive), .mgr_bit(mgr_bit),
    .mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n), .mdc(mdc), .mdio_i(mdio_i));

  always #50 clk_sys = ~clk_sys;

  always @(posedge clk_sys)
  begin
    rq <= rx_clk;
    if (med_tx_valid === 1'b1)
      txq.push_back(med_tx_data);
    if (cfg_mode == PMI_RMII ? rx_dv : (rx_clk && !rq && crs && (rx_dv || cfg_mode == PMI_SERIAL)))
      rxq.push_back({rx_er, rxd & msk});
    col_cnt += (col === 1'b1);
    mac_cnt += (mac_col === 1'b1);
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic print_verdict();
    if (miscompares == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic set_cfg(input pmi_mode_type m, input logic f, input logic fd, input logic hb);
    cfg_mode <= m;
    cfg_fast <= f;
    cfg_full <= fd;
    cfg_heartbeat <= hb;
    tick(6);
  endtask

  task automatic send(input logic [5:0] n, input logic [31:0] b);
    units <= n;
    bits <= b;
    go <= 1'b1;
    while (busy !== 1'b1) tick(1);
    go <= 1'b0;
    while (busy !== 1'b0) tick(1);
    tick(12);
  endtask

  // one read after each edge sees the ready that edge sampled
  task automatic recv(input int n, input logic [3:0] base, input logic err, input logic fc);
    refused = 0;
    med_rx_carrier <= 1'b1;
    med_rx_false_carrier <= fc;
    for (int i = 0; i < n; i++)
    begin
      med_rx_valid <= 1'b1;
      med_rx_data <= base + i[3:0];
      med_rx_sym_err <= err && (i == 1);
      tick(1);
      while (med_rx_ready !== 1'b1)
      begin
        refused++;
        tick(1);
      end
    end
    med_rx_valid <= 1'b0;
    tick(8 * n + 20);
    `CHK("carrier busy", 1'b1, crs)
    med_rx_carrier <= 1'b0;
    med_rx_false_carrier <= 1'b0;
    tick(10);
    `CHK("carrier idle", 1'b0, crs)
  endtask

  task automatic chk_rx(input int n, input logic [3:0] base, input logic err, input logic fc);
    logic [4:0] ex[$];
    int w, hit;
    logic er;
    logic [3:0] nib;
    w = (cfg_mode == PMI_MII) ? 4 : (cfg_mode == PMI_RMII) ? 2 : 1;
    hit = 0;
    for (int i = 0; i < n; i++)
    begin
      nib = base + i[3:0];
      er = cfg_fast && cfg_mode != PMI_SERIAL && ((err && i == 1) || (fc && cfg_mode == PMI_RMII));
      for (int k = 0; k < 4; k += w)
        ex.push_back({er, (er && cfg_mode == PMI_RMII) ? {2'h0, RMII_ERR_CODE} : ((nib >> k) & msk)});
    end
    for (int o = 0; o + ex.size() <= rxq.size() && hit == 0; o++)
    begin
      hit = 1;
      foreach (ex[j])
        if (rxq[o + j] !== ex[j])
          hit = 0;
    end
    `CHK("rx units", 1, hit)
  endtask

  task automatic chk_clk(input int per);
    int tr, rr;
    logic tq, rq2;
    tr = 0;
    rr = 0;
    tq = tx_clk;
    rq2 = rx_clk;
    repeat (24)
    begin
      tick(1);
      tr += (tx_clk && !tq);
      rr += (rx_clk && !rq2);
      tq = tx_clk;
      rq2 = rx_clk;
    end
    `CHK("tx clk rises", (per == 0) ? 0 : 24 / per, tr)
    `CHK("rx clk rises", (per == 0) ? 0 : 24 / per, rr)
  endtask

  task automatic coll(input pmi_mode_type m, input logic f, input logic fd, input logic hb,
                      input logic car, input int exp_n);
    int c0, m0;
    set_cfg(m, f, fd, hb);
    c0 = col_cnt;
    m0 = mac_cnt;
    med_rx_carrier <= car;
    send(6'd8, 32'hAAAA);
    med_rx_carrier <= 1'b0;
    tick(20);
    c0 = col_cnt - c0;
    `CHK("collision cycles", exp_n, (exp_n == 1 && c0 > 0) ? 1 : c0)
    `CHK("mac collision", car, mac_cnt > m0)
  endtask

  initial
  begin
    tick(9);
    `CHK("reset outputs", 19'h00700, {tx_clk, rx_clk, rx_dv, rx_er, crs, col, med_tx_valid,
      med_rx_ready, mdio_o, mdio_oe_n, mgmt_mdio_in, rxd, med_tx_data})
    tick(1);
    rstn <= 1'b1;
    tick(3);
    for (int r = 0; r < 5; r++)
    begin
      set_cfg(rm[r], rf[r], 1'b0, 1'b0);
      chk_clk(rp[r]);
      txq.delete();
      send(tu[r][5:0], tw[r]);
      `CHK("tx count", tn[r], txq.size())
      foreach (txq[i]) `CHK("tx nibble", tw[r][4 * i +: 4], txq[i])
      rxq.delete();
      recv(2, 4'h3 + r[3:0], 1'b1, rc[r]);
      chk_rx(2, 4'h3 + r[3:0], 1'b1, rc[r]);
    end
    set_cfg(PMI_MII, 1'b0, 1'b0, 1'b0);
    rxq.delete();
    recv(48, 4'h0, 1'b0, 1'b0);
    `CHK("fifo refused", 1, refused > 0)
    chk_rx(48, 4'h0, 1'b0, 1'b0);
    coll(PMI_MII, 1'b1, 1'b0, 1'b0, 1'b1, 1);
    coll(PMI_MII, 1'b1, 1'b1, 1'b0, 1'b1, 0);
    coll(PMI_SERIAL, 1'b0, 1'b0, 1'b0, 1'b1, 1);
    coll(PMI_RMII, 1'b1, 1'b0, 1'b0, 1'b1, 0);
    coll(PMI_MII, 1'b0, 1'b0, 1'b1, 1'b0, SQE_CYCLES);
    coll(PMI_MII, 1'b0, 1'b1, 1'b1, 1'b0, 0);
    set_cfg(PMI_MII, 1'b1, 1'b0, 1'b0);
    med_rx_carrier <= 1'b1;
    cfg_mode <= PMI_RMII;
    chk_clk(2 * HALF_MII_FAST);
    med_rx_carrier <= 1'b0;
    mgmt_drive <= 1'b1;
    mgmt_bit <= 1'b0;
    tick(8);
    `CHK("mdio device drive", 3'b000, {mdio_oe_n, mdio_o, mgmt_mdio_in})
    mgmt_drive <= 1'b0;
    mgr_drive <= 1'b1;
    mgr_bit <= 1'b0;
    tick(30);
    `CHK("mdio manager drive", 2'b10, {mdio_oe_n, mgmt_mdio_in})
    a = mgmt_mdc;
    tick(5);
    `CHK("mdc follows", ~a, mgmt_mdc)
    mgr_drive <= 1'b0;
    tick(8);
    `CHK("mdio released", 1'b1, mgmt_mdio_in)
    print_verdict();
  end

  initial
  begin
    tick(10000);
    miscompares++;
    print_verdict();
  end
endmodule
